// file: rtl/ecs_error_capture.sv
`timescale 1ns/1ps
module ecs_error_capture
  import ecs_pkg::*;
#(
  parameter int MEM_ADDR_W = MEM_ADDR_W_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  // register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // memory controller reports
  input wire logic secded_err,
  input wire logic [SYN_W-1:0] secded_syndrome,
  input wire logic [MEM_ADDR_W-1:0] secded_addr,
  input wire logic parity_err,
  input wire logic [CODE_W-1:0] parity_port,
  input wire logic bp_match,
  input wire logic [CODE_W-1:0] bp_port,
  input wire logic [CODE_W-1:0] bp_func,
  output logic irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rstn_int;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rstn_int = rst_sync2_reg;

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  // the write lands one cycle after both halves are held; simpler than a bypass
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_lane0 = wr_go && wstrb0_reg;
  wire wr_mapped = (aw_idx_reg >= IDX_SYNDROME_WORD) && (aw_idx_reg <= IDX_IRQ_MASK);
  wire wr_ctrl = wr_lane0 && (aw_idx_reg == IDX_CONTROL);
  wire wr_flags = wr_lane0 && (aw_idx_reg == IDX_FLAGS);
  wire wr_mask = wr_lane0 && (aw_idx_reg == IDX_IRQ_MASK);

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[IDX_W+ADDR_LSB-1:ADDR_LSB];
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic large_cfg_reg;
  logic [FLAG_N-1:0] mask_reg;

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      large_cfg_reg <= 1'b0;
      mask_reg <= MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        large_cfg_reg <= wdata_reg[CTRL_LARGE_BIT];
      end
      if (wr_mask) begin
        mask_reg <= wdata_reg[FLAG_N-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags and capture locks
  // ----------------------------------------------------------------
  logic [FLAG_N-1:0] flag_reg;
  logic [FLAG_N-1:0] flag_next;
  wire [FLAG_N-1:0] event_in = {bp_match, parity_err, secded_err};
  wire [FLAG_N-1:0] flag_clr = wr_flags ? wdata_reg[FLAG_N-1:0] : '0;
  // a field reloads only when its flag is clear or being cleared now
  wire [FLAG_N-1:0] load = event_in & (~flag_reg | flag_clr);

  // a new event beats a software clear in the same cycle
  assign flag_next = event_in | (flag_reg & ~flag_clr);

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      flag_reg <= FLAGS_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // captured fields
  // ----------------------------------------------------------------
  logic [SYN_W-1:0] syndrome_reg;
  logic [FAIL_ADDR_W-1:0] fail_addr_reg;
  logic [CODE_W-1:0] pe_port_reg;
  logic [CODE_W-1:0] bp_port_reg;
  logic [CODE_W-1:0] bp_func_reg;
  wire [FAIL_ADDR_W-1:0] addr_small = {secded_addr[SMALL_B53], secded_addr[SMALL_B52],
    secded_addr[SMALL_B51], secded_addr[LOW_ADDR_BITS-1:0]};
  wire [FAIL_ADDR_W-1:0] addr_large = {secded_addr[LARGE_B53], secded_addr[LARGE_B52],
    secded_addr[LARGE_B51], secded_addr[LOW_ADDR_BITS-1:0]};
  // configuration is sampled at capture, so a later change leaves the field alone
  wire [FAIL_ADDR_W-1:0] addr_pick = large_cfg_reg ? addr_large : addr_small;

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      syndrome_reg <= '0;
      fail_addr_reg <= '0;
    end else if (load[FLAG_SECDED]) begin
      syndrome_reg <= secded_syndrome;
      fail_addr_reg <= addr_pick;
    end
  end

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      pe_port_reg <= '0;
    end else if (load[FLAG_PARITY]) begin
      pe_port_reg <= parity_port;
    end
  end

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      bp_port_reg <= '0;
      bp_func_reg <= '0;
    end else if (load[FLAG_BREAK]) begin
      bp_port_reg <= bp_port;
      bp_func_reg <= bp_func;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, cleared by reading it
  // ----------------------------------------------------------------
  logic [FLAG_N-1:0] irq_stat_reg;
  logic [FLAG_N-1:0] irq_stat_next;
  logic ar_fire;
  logic [IDX_W-1:0] rd_idx;
  wire rd_irq_clear = ar_fire && (rd_idx == IDX_IRQ_STATUS);

  assign irq_stat_next = event_in | (rd_irq_clear ? '0 : irq_stat_reg);
  assign irq = |(irq_stat_reg & mask_reg);

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      irq_stat_reg <= FLAGS_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire [WORD_BITS-1:0] word_syn = WORD_BITS'(syndrome_reg) << SYN_OFS;
  wire [WORD_BITS-1:0] word_addr = (WORD_BITS'(fail_addr_reg) << ADDR_OFS)
    | (WORD_BITS'(pe_port_reg) << PE_PORT_OFS)
    | (WORD_BITS'(bp_port_reg) << BP_PORT_OFS)
    | (WORD_BITS'(bp_func_reg) << BP_FUNC_OFS);
  wire sel_syn = rd_idx == IDX_SYNDROME_WORD;
  wire sel_addr = rd_idx == IDX_ADDR_PORT_WORD;
  wire sel_ctrl = rd_idx == IDX_CONTROL;
  wire sel_flags = rd_idx == IDX_FLAGS;
  wire sel_stat = rd_idx == IDX_IRQ_STATUS;
  wire sel_mask = rd_idx == IDX_IRQ_MASK;
  wire rd_mapped = sel_syn | sel_addr | sel_ctrl | sel_flags | sel_stat | sel_mask;
  wire [DATA_W-1:0] rd_mux = ({DATA_W{sel_syn}} & DATA_W'(word_syn))
    | ({DATA_W{sel_addr}} & DATA_W'(word_addr))
    | ({DATA_W{sel_ctrl}} & DATA_W'(large_cfg_reg))
    | ({DATA_W{sel_flags}} & DATA_W'(flag_reg))
    | ({DATA_W{sel_stat}} & DATA_W'(irq_stat_reg))
    | ({DATA_W{sel_mask}} & DATA_W'(mask_reg));

  assign rd_idx = s_axi_araddr[IDX_W+ADDR_LSB-1:ADDR_LSB];
  assign s_axi_arready = !rvalid_reg;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge clock or negedge rstn_int) begin
    if (!rstn_int) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn_int);

  sequence s_parity_load;
    parity_err && !flag_reg[FLAG_PARITY];
  endsequence

  sequence s_break_load;
    bp_match && !flag_reg[FLAG_BREAK];
  endsequence

  sequence s_secded_load_small;
    secded_err && !flag_reg[FLAG_SECDED] && !large_cfg_reg;
  endsequence

  sequence s_secded_load_large;
    secded_err && !flag_reg[FLAG_SECDED] && large_cfg_reg;
  endsequence

  sequence s_read_addr_word;
    ar_fire && sel_addr;
  endsequence

  a_port_load: assert property (s_parity_load |=>
    flag_reg[FLAG_PARITY] && pe_port_reg == $past(parity_port))
    else $error("parity port code not loaded");

  a_port_hold: assert property (flag_reg[FLAG_PARITY] && !flag_clr[FLAG_PARITY] |=>
    $stable(pe_port_reg))
    else $error("parity port code changed while locked");

  a_break_load: assert property (s_break_load |=>
    bp_port_reg == $past(bp_port) && bp_func_reg == $past(bp_func))
    else $error("breakpoint codes not loaded");

  a_break_hold: assert property (flag_reg[FLAG_BREAK] && !flag_clr[FLAG_BREAK] |=>
    $stable(bp_port_reg) && $stable(bp_func_reg))
    else $error("breakpoint codes changed while locked");

  a_addr_small: assert property (s_secded_load_small |=>
    fail_addr_reg[LOW_ADDR_BITS] == $past(secded_addr[SMALL_B51])
    && fail_addr_reg[LOW_ADDR_BITS+1] == $past(secded_addr[SMALL_B52]))
    else $error("small configuration address bits wrong");

  a_addr_large: assert property (s_secded_load_large |=>
    fail_addr_reg[LOW_ADDR_BITS] == $past(secded_addr[LARGE_B51])
    && fail_addr_reg[LOW_ADDR_BITS+1] == $past(secded_addr[LARGE_B52]))
    else $error("large configuration address bits wrong");

  a_addr_top: assert property ((s_secded_load_small or s_secded_load_large) |=>
    fail_addr_reg[LOW_ADDR_BITS+2] == ($past(large_cfg_reg) ? $past(secded_addr[LARGE_B53])
    : $past(secded_addr[SMALL_B53])))
    else $error("address status bit 53 wrong");

  a_addr_low: assert property ((s_secded_load_small or s_secded_load_large) |=>
    fail_addr_reg[LOW_ADDR_BITS-1:0] == $past(secded_addr[LOW_ADDR_BITS-1:0]))
    else $error("failing address low bits wrong");

  a_syn_capture: assert property (secded_err && !flag_reg[FLAG_SECDED] |=>
    syndrome_reg == $past(secded_syndrome) && flag_reg[FLAG_SECDED])
    else $error("syndrome not captured");

  a_syn_hold: assert property (flag_reg[FLAG_SECDED] && !flag_clr[FLAG_SECDED] |=>
    $stable(syndrome_reg) && $stable(fail_addr_reg))
    else $error("syndrome capture changed while locked");

  a_word4_read: assert property (s_read_addr_word ##1 s_axi_rvalid |->
    s_axi_rdata[PE_PORT_OFS +: CODE_W] == $past(pe_port_reg)
    && s_axi_rdata[BP_FUNC_OFS +: CODE_W] == $past(bp_func_reg))
    else $error("status word codes misplaced");

endmodule // ecs_error_capture

// file: rtl/ecs_pkg.sv
package ecs_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int ADDR_LSB = 2;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_SYNDROME_WORD = 6'h03;
  localparam logic [IDX_W-1:0] IDX_ADDR_PORT_WORD = 6'h04;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 6'h05;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h06;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h07;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h08;

  // ----------------------------------------------------------------
  // status word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 12;
  localparam int SYN_POS = 40;
  localparam int ADDR_POS = 48;
  localparam int PE_PORT_POS = 54;
  localparam int BP_PORT_POS = 56;
  localparam int BP_FUNC_POS = 58;
  localparam int SYN_OFS = SYN_POS % WORD_BITS;
  localparam int ADDR_OFS = ADDR_POS % WORD_BITS;
  localparam int PE_PORT_OFS = PE_PORT_POS % WORD_BITS;
  localparam int BP_PORT_OFS = BP_PORT_POS % WORD_BITS;
  localparam int BP_FUNC_OFS = BP_FUNC_POS % WORD_BITS;
  localparam int SYN_W = 8;
  localparam int FAIL_ADDR_W = 6;
  localparam int CODE_W = 2;

  // ----------------------------------------------------------------
  // memory address bits picked for status bits 51..53
  // ----------------------------------------------------------------
  localparam int LOW_ADDR_BITS = 3;
  localparam int SMALL_B51 = 15;
  localparam int SMALL_B52 = 16;
  localparam int SMALL_B53 = 17;
  localparam int LARGE_B51 = 16;
  localparam int LARGE_B52 = 17;
  localparam int LARGE_B53 = 3;
  localparam int MEM_ADDR_W_DEF = 18;

  // ----------------------------------------------------------------
  // event flags: syndrome (bit 3), parity (bit 5), breakpoint (bit 77)
  // ----------------------------------------------------------------
  localparam int FLAG_N = 3;
  localparam int FLAG_SECDED = 0;
  localparam int FLAG_PARITY = 1;
  localparam int FLAG_BREAK = 2;
  localparam int CTRL_LARGE_BIT = 0;
  localparam logic [FLAG_N-1:0] FLAGS_RESET = 3'h0;
  localparam logic [FLAG_N-1:0] MASK_RESET = 3'h0;

endpackage

// file: tb/ecs_error_capture_tb.sv
`timescale 1ns/1ps
module ecs_error_capture_tb;
  import ecs_pkg::*;
  logic clock, rstn;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic secded_err, parity_err, bp_match;
  logic [7:0] secded_syndrome;
  logic [17:0] secded_addr;
  logic [1:0] parity_port, bp_port, bp_func;
  logic [5:0] e_fa;
  logic [1:0] e_pc, e_bpp, e_bpf;
  int fails, check_count, cyc;
  localparam logic [17:0] ADR = 18'h2800D;

  ecs_error_capture i_ecs_error_capture (.clock, .rstn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .secded_err, .secded_syndrome, .secded_addr,
    .parity_err, .parity_port, .bp_match, .bp_port, .bp_func, .irq);
  ecs_mem_ctrl_model i_ecs_mem_ctrl_model (.clock, .secded_err, .secded_syndrome, .secded_addr,
    .parity_err, .parity_port, .bp_match, .bp_port, .bp_func);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ready is sampled at the falling edge, where it is settled, and acted on at the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (!tb);
    chk("bresp", 32'(er), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                    input string nm);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end while (!tr);
    chk(nm, ed, d);
    chk("rresp", 32'(er), 32'(r));
  endtask

  task automatic rd_word();
    rd(8'h10, {20'h0, e_bpf, e_bpp, e_pc, e_fa}, RESP_OKAY, "addr_word");
  endtask

  task automatic irq_is(input logic e);
    @(negedge clock);
    chk("irq", 32'(e), 32'(irq));
    @(posedge clock);
  endtask

  function automatic logic [5:0] fa(input logic [17:0] a, input logic lg);
    return lg ? {a[3], a[17], a[16], a[2:0]} : {a[17], a[16], a[15], a[2:0]};
  endfunction

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {e_fa, e_pc, e_bpp, e_bpf} = '0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    for (int i = 5; i <= 8; i++) rd(8'(4 * i), 32'h0, RESP_OKAY, "reset_value");
    rd(8'h40, 32'h0, RESP_DECERR, "unmapped");
    wr(8'h40, 32'hFFF, RESP_DECERR);
    wr(8'h0C, 32'hFFF, RESP_OKAY);
    // a write without byte lane 0 must leave the control bit alone
    s_axi_wstrb <= 4'hE;
    wr(8'h14, 32'h1, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(8'h14, 32'h0, RESP_OKAY, "control_no_lane0");
    $display("test registers done");

    wr(8'h20, 32'h7, RESP_OKAY);
    i_ecs_mem_ctrl_model.send(3'h1, 8'hA5, ADR, 2'h0, 2'h0, 2'h0);
    i_ecs_mem_ctrl_model.send(3'h1, 8'h5A, ~ADR, 2'h0, 2'h0, 2'h0);
    e_fa = fa(ADR, 1'b0);
    irq_is(1'b1);
    rd(8'h18, 32'h1, RESP_OKAY, "flags");
    rd(8'h0C, 32'hA50, RESP_OKAY, "syndrome");
    rd_word();
    rd(8'h1C, 32'h1, RESP_OKAY, "irq_status");
    rd(8'h1C, 32'h0, RESP_OKAY, "irq_status");
    irq_is(1'b0);
    $display("test small capture done");

    // large configuration picks address bits 16, 17 and 3
    wr(8'h18, 32'h1, RESP_OKAY);
    wr(8'h14, 32'h1, RESP_OKAY);
    rd(8'h14, 32'h1, RESP_OKAY, "control");
    i_ecs_mem_ctrl_model.send(3'h1, 8'h3C, ADR, 2'h0, 2'h0, 2'h0);
    e_fa = fa(ADR, 1'b1);
    rd(8'h0C, 32'h3C0, RESP_OKAY, "syndrome");
    rd_word();
    $display("test large capture done");

    for (int c = 0; c < 4; c++) begin
      wr(8'h18, 32'h2, RESP_OKAY);
      i_ecs_mem_ctrl_model.send(3'h2, 8'h00, 18'h0, 2'(c), 2'h0, 2'h0);
      i_ecs_mem_ctrl_model.send(3'h2, 8'h00, 18'h0, ~2'(c), 2'h0, 2'h0);
      e_pc = 2'(c);
      rd_word();
    end
    $display("test parity port done");

    for (int c = 0; c < 4; c++) begin
      wr(8'h18, 32'h4, RESP_OKAY);
      i_ecs_mem_ctrl_model.send(3'h4, 8'h00, 18'h0, 2'h0, 2'(c), ~2'(c));
      i_ecs_mem_ctrl_model.send(3'h4, 8'h00, 18'h0, 2'h0, ~2'(c), 2'(c));
      e_bpp = 2'(c);
      e_bpf = ~2'(c);
      rd_word();
    end
    $display("test breakpoint done");

    // masked events set status but keep the line low
    rd(8'h1C, 32'h7, RESP_OKAY, "irq_status");
    wr(8'h20, 32'h0, RESP_OKAY);
    wr(8'h18, 32'h7, RESP_OKAY);
    i_ecs_mem_ctrl_model.send(3'h7, 8'h81, ~ADR, 2'h1, 2'h2, 2'h3);
    {e_fa, e_pc, e_bpp, e_bpf} = {fa(~ADR, 1'b1), 2'h1, 2'h2, 2'h3};
    irq_is(1'b0);
    wr(8'h20, 32'h2, RESP_OKAY);
    irq_is(1'b1);
    rd(8'h1C, 32'h7, RESP_OKAY, "irq_status");
    irq_is(1'b0);
    rd(8'h18, 32'h7, RESP_OKAY, "flags");
    rd(8'h0C, 32'h810, RESP_OKAY, "syndrome");
    rd_word();
    $display("test mask done");
    results();
  end
endmodule // ecs_error_capture_tb

// file: tb/ecs_mem_ctrl_model.sv
`timescale 1ns/1ps
module ecs_mem_ctrl_model
  import ecs_pkg::*;
(
  input wire logic clock,
  output logic secded_err,
  output logic [SYN_W-1:0] secded_syndrome,
  output logic [MEM_ADDR_W_DEF-1:0] secded_addr,
  output logic parity_err,
  output logic [CODE_W-1:0] parity_port,
  output logic bp_match,
  output logic [CODE_W-1:0] bp_port,
  output logic [CODE_W-1:0] bp_func
);
  // ----------------------------------------------------------------
  // report driver
  // ----------------------------------------------------------------
  initial begin
    {secded_err, parity_err, bp_match} = 3'h0;
    {secded_syndrome, secded_addr, parity_port, bp_port, bp_func} = '0;
  end

  // one-cycle report; afterwards the payload is inverted, since it is no longer
  // valid and a frozen field must not follow it
  task automatic send(input logic [2:0] ev, input logic [7:0] syn, input logic [17:0] adr,
                      input logic [1:0] pc, input logic [1:0] bpp, input logic [1:0] bpf);
    @(posedge clock);
    secded_err <= ev[0];
    parity_err <= ev[1];
    bp_match <= ev[2];
    secded_syndrome <= syn;
    secded_addr <= adr;
    parity_port <= pc;
    bp_port <= bpp;
    bp_func <= bpf;
    @(posedge clock);
    {secded_err, parity_err, bp_match} <= 3'h0;
    {secded_syndrome, secded_addr} <= ~{syn, adr};
    {parity_port, bp_port, bp_func} <= ~{pc, bpp, bpf};
  endtask
endmodule // ecs_mem_ctrl_model
